/* File: core/dsfr_pkg.sv */
// Constants and types for the loop status and feedback register slice.
package dsfr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS  = 8'h44;
  localparam logic [7:0] ADDR_FB     = 8'h45;
  localparam logic [7:0] ADDR_PWR    = 8'h46;
  localparam logic [7:0] ADDR_PML0   = 8'h47;
  localparam logic [7:0] ADDR_PML1   = 8'h48;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_FB      = 8'h00;
  localparam logic [7:0] RST_PWR     = 8'hff;
  localparam logic [7:0] RST_PML     = 8'h0a;
  localparam logic [7:0] RDATA_NONE  = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLAG_HOLD0  = 0;
  localparam int FLAG_LOCK0  = 1;
  localparam int FLAG_HOLD1  = 2;
  localparam int FLAG_LOCK1  = 3;
  localparam logic [7:0] FLAG_MASK = 8'h0f;
  localparam int FB_LOOP     = 0;
  localparam int FB_SRC_LO   = 2;
  localparam int FB_SRC_HI   = 3;
  localparam int FB_ON       = 7;
  localparam logic [7:0] FB_MASK = 8'h8d;
  localparam int MODE_FB_ON  = 5;
  // Phase memory codes for typical limits.
  localparam logic [7:0] PML_10US  = 8'h00;
  localparam logic [7:0] PML_100US = 8'h20;
  localparam logic [7:0] PML_1MS   = 8'h40;
  // ****************************************
  // Feedback phase datapath
  // ****************************************
  localparam int PHW   = 16;
  localparam int NREF  = 4;
  localparam int NLOOP = 2;
  localparam logic [PHW-1:0] PHASE_ZERO = 16'h0000;
  typedef logic [PHW-1:0] dsfr_phase_t;
endpackage

/* File: core/dsfr_fb_phase.sv */
// Feedback phase measurement and per-loop phase compensation.
`timescale 1ns/100ps
module dsfr_fb_phase (
  input  wire logic                                        clock,
  input  wire logic                                        rst_n,
  input  wire logic                                        ce,
  input  wire logic                                        feedback_measure_on,
  input  wire logic                                        feedback_loop_choice,
  input  wire logic [1:0]                                  feedback_source_choice,
  input  wire logic [dsfr_pkg::NREF-1:0][dsfr_pkg::PHW-1:0] ref_phase,
  input  wire logic [dsfr_pkg::NLOOP-1:0][1:0]             loop_active_ref,
  input  wire logic [dsfr_pkg::NLOOP-1:0]                  loop_feedback_compensate_on,
  output logic      [dsfr_pkg::PHW-1:0]                    feedback_phase,
  output logic      [dsfr_pkg::NLOOP-1:0][dsfr_pkg::PHW-1:0] loop_comp_phase
);
  typedef struct packed {
    dsfr_pkg::dsfr_phase_t                             phase;
    logic [dsfr_pkg::NLOOP-1:0][dsfr_pkg::PHW-1:0]     comp;
  } dsfr_fb_state_t;

  dsfr_fb_state_t q;
  dsfr_fb_state_t d;
  logic [1:0]     main_ref;
  dsfr_pkg::dsfr_phase_t phase_d;
  logic [dsfr_pkg::NLOOP-1:0][dsfr_pkg::PHW-1:0] comp_d;

  // The chosen loop's active reference is compared with the feedback source.
  assign main_ref = loop_active_ref[feedback_loop_choice];

  // The difference is formed apart from the state copy, so that the per-loop
  // compensation does not read back through the struct that it fills.
  always_comb begin
    phase_d = dsfr_pkg::PHASE_ZERO;
    if (feedback_measure_on) begin
      phase_d = ref_phase[main_ref] - ref_phase[feedback_source_choice];
    end
  end

  // Compensation follows each loop's own enable, not the loop chosen for measuring.
  for (genvar i = 0; i < dsfr_pkg::NLOOP; i++) begin : g_comp
    assign comp_d[i] = loop_feedback_compensate_on[i] ? phase_d : dsfr_pkg::PHASE_ZERO;
  end

  always_comb begin
    d       = q;
    d.phase = phase_d;
    d.comp  = comp_d;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign feedback_phase  = q.phase;
  assign loop_comp_phase = q.comp;

  AST_FB_OFF_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !feedback_measure_on |=> feedback_phase == dsfr_pkg::PHASE_ZERO)
    else $error("Feedback phase not zero while measurement is off.");
  AST_FB_DIFF: assert property (@(posedge clock) disable iff (!rst_n)
    ce && feedback_measure_on |=> feedback_phase ==
      $past(ref_phase[loop_active_ref[feedback_loop_choice]] -
            ref_phase[feedback_source_choice]))
    else $error("Feedback phase does not match the chosen loop and source.");
  AST_COMP_LOOP0: assert property (@(posedge clock) disable iff (!rst_n)
    ce && loop_feedback_compensate_on[0] |=> loop_comp_phase[0] == feedback_phase)
    else $error("First loop not compensated by the feedback phase.");
  AST_COMP_LOOP1_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !loop_feedback_compensate_on[1] |=> loop_comp_phase[1] == dsfr_pkg::PHASE_ZERO)
    else $error("Second loop compensated while its enable is clear.");
endmodule

/* File: core/dsfr_regs.sv */
// Loop status flags, feedback control, output power and phase memory registers.
`timescale 1ns/100ps
module dsfr_regs (
  input  wire logic                                        clock,
  input  wire logic                                        nrst,
  input  wire logic                                        ce,
  input  wire logic [7:0]                                  reg_addr,
  input  wire logic                                        reg_wr,
  input  wire logic                                        reg_rd,
  input  wire logic [7:0]                                  reg_wdata,
  output logic      [7:0]                                  reg_rdata,
  input  wire logic                                        first_loop_holdover,
  input  wire logic                                        first_loop_locked,
  input  wire logic                                        second_loop_holdover,
  input  wire logic                                        second_loop_locked,
  input  wire logic [7:0]                                  first_loop_mode,
  input  wire logic [7:0]                                  second_loop_mode,
  input  wire logic [dsfr_pkg::NREF-1:0][dsfr_pkg::PHW-1:0] ref_phase,
  input  wire logic [dsfr_pkg::NLOOP-1:0][1:0]             loop_active_ref,
  output logic      [7:0]                                  diff_output_low_power,
  output logic      [7:0]                                  input0_phase_memory_code,
  output logic      [7:0]                                  input1_phase_memory_code,
  output logic                                             feedback_measure_on,
  output logic                                             feedback_loop_choice,
  output logic      [1:0]                                  feedback_source_choice,
  output logic      [dsfr_pkg::PHW-1:0]                    feedback_phase,
  output logic      [dsfr_pkg::NLOOP-1:0][dsfr_pkg::PHW-1:0] loop_comp_phase
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] fb_ctrl;
    logic [7:0] pwr;
    logic [7:0] pml0;
    logic [7:0] pml1;
    logic [7:0] rdata;
  } dsfr_regs_state_t;

  localparam dsfr_regs_state_t STATE_RST = '{
    flags:   dsfr_pkg::RST_FLAGS,
    fb_ctrl: dsfr_pkg::RST_FB,
    pwr:     dsfr_pkg::RST_PWR,
    pml0:    dsfr_pkg::RST_PML,
    pml1:    dsfr_pkg::RST_PML,
    rdata:   dsfr_pkg::RDATA_NONE
  };

  dsfr_regs_state_t q;
  dsfr_regs_state_t d;
  logic             rst_s1_q;
  logic             rst_n;
  logic [7:0]       flag_set;
  logic [dsfr_pkg::NLOOP-1:0] comp_on;

  // ****************************************
  // Reset release
  // ****************************************
  // Release is synchronised so no register leaves reset on a different edge.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ****************************************
  // Register logic
  // ****************************************
  // Status comes straight from the loops; no mask stands in its path.
  always_comb begin
    flag_set = 8'h00;
    flag_set[dsfr_pkg::FLAG_HOLD0] = first_loop_holdover;
    flag_set[dsfr_pkg::FLAG_LOCK0] = first_loop_locked;
    flag_set[dsfr_pkg::FLAG_HOLD1] = second_loop_holdover;
    flag_set[dsfr_pkg::FLAG_LOCK1] = second_loop_locked;
  end

  always_comb begin
    d = q;
    d.rdata = dsfr_pkg::RDATA_NONE;
    if (reg_rd) begin
      case (reg_addr)
        dsfr_pkg::ADDR_FLAGS: d.rdata = q.flags;
        dsfr_pkg::ADDR_FB:    d.rdata = q.fb_ctrl;
        dsfr_pkg::ADDR_PWR:   d.rdata = q.pwr;
        dsfr_pkg::ADDR_PML0:  d.rdata = q.pml0;
        dsfr_pkg::ADDR_PML1:  d.rdata = q.pml1;
        default:              d.rdata = dsfr_pkg::RDATA_NONE;
      endcase
    end
    // A read clears what it returned; a condition present in the same cycle sets again.
    if (reg_rd && reg_addr == dsfr_pkg::ADDR_FLAGS) begin
      d.flags = dsfr_pkg::RST_FLAGS;
    end
    d.flags = (d.flags | flag_set) & dsfr_pkg::FLAG_MASK;
    if (reg_wr) begin
      case (reg_addr)
        dsfr_pkg::ADDR_FB:   d.fb_ctrl = reg_wdata & dsfr_pkg::FB_MASK;
        dsfr_pkg::ADDR_PWR:  d.pwr = reg_wdata;
        dsfr_pkg::ADDR_PML0: d.pml0 = reg_wdata;
        dsfr_pkg::ADDR_PML1: d.pml1 = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata                = q.rdata;
  assign diff_output_low_power    = q.pwr;
  assign input0_phase_memory_code = q.pml0;
  assign input1_phase_memory_code = q.pml1;
  assign feedback_measure_on      = q.fb_ctrl[dsfr_pkg::FB_ON];
  assign feedback_loop_choice     = q.fb_ctrl[dsfr_pkg::FB_LOOP];
  assign feedback_source_choice   = q.fb_ctrl[dsfr_pkg::FB_SRC_HI:dsfr_pkg::FB_SRC_LO];

  // Mode registers live elsewhere; only the compensation bit is taken here.
  assign comp_on[0] = first_loop_mode[dsfr_pkg::MODE_FB_ON];
  assign comp_on[1] = second_loop_mode[dsfr_pkg::MODE_FB_ON];

  // ****************************************
  // Feedback phase
  // ****************************************
  dsfr_fb_phase u_fb_phase (
    .clock                       (clock),
    .rst_n                       (rst_n),
    .ce                          (ce),
    .feedback_measure_on         (feedback_measure_on),
    .feedback_loop_choice        (feedback_loop_choice),
    .feedback_source_choice      (feedback_source_choice),
    .ref_phase                   (ref_phase),
    .loop_active_ref             (loop_active_ref),
    .loop_feedback_compensate_on (comp_on),
    .feedback_phase              (feedback_phase),
    .loop_comp_phase             (loop_comp_phase)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_flags_read;
    ce && reg_rd && reg_addr == dsfr_pkg::ADDR_FLAGS;
  endsequence

  AST_HOLD0_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && first_loop_holdover |=> q.flags[dsfr_pkg::FLAG_HOLD0])
    else $error("First loop holdover flag did not set.");
  AST_LOCK0_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && first_loop_locked |=> q.flags[dsfr_pkg::FLAG_LOCK0])
    else $error("First loop lock flag did not set.");
  AST_LOOP1_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && second_loop_holdover && second_loop_locked |=>
      q.flags[dsfr_pkg::FLAG_LOCK1:dsfr_pkg::FLAG_HOLD1] == 2'h3)
    else $error("Second loop flags did not set.");
  AST_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !(reg_rd && reg_addr == dsfr_pkg::ADDR_FLAGS) |=>
      (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("Flag cleared without a read.");
  AST_READ_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    s_flags_read ##0 !(first_loop_holdover || first_loop_locked ||
      second_loop_holdover || second_loop_locked) |=> q.flags == dsfr_pkg::RST_FLAGS ##0
      reg_rdata == $past(q.flags))
    else $error("Flag read did not return and clear the flags.");
  AST_NO_MASK: assert property (@(posedge clock) disable iff (!rst_n)
    s_flags_read ##0 first_loop_holdover |=> q.flags[dsfr_pkg::FLAG_HOLD0])
    else $error("Holdover flag lost on a clearing read.");
  AST_PWR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reg_wr && reg_addr == dsfr_pkg::ADDR_PWR |=> diff_output_low_power == $past(reg_wdata))
    else $error("Output power register not written.");
  AST_PML_INDEP: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reg_wr && reg_addr == dsfr_pkg::ADDR_PML0 |=> $stable(input1_phase_memory_code))
    else $error("Reference 1 limit changed by a reference 0 write.");
  AST_FB_FIELDS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reg_wr && reg_addr == dsfr_pkg::ADDR_FB |=>
      feedback_source_choice == $past(reg_wdata[dsfr_pkg::FB_SRC_HI:dsfr_pkg::FB_SRC_LO]) &&
      feedback_measure_on == $past(reg_wdata[dsfr_pkg::FB_ON]))
    else $error("Feedback control fields not taken from the write.");

  // The flag register is read-only; a write to its address must leave it alone.
  sequence s_flags_write_only;
    ce && reg_wr && !reg_rd && reg_addr == dsfr_pkg::ADDR_FLAGS;
  endsequence

  sequence s_no_status;
    !(first_loop_holdover || first_loop_locked || second_loop_holdover || second_loop_locked);
  endsequence

  sequence s_pml0_write;
    ce && reg_wr && reg_addr == dsfr_pkg::ADDR_PML0;
  endsequence

  sequence s_pml1_write;
    ce && reg_wr && reg_addr == dsfr_pkg::ADDR_PML1;
  endsequence

  sequence s_pwr_read;
    ce && reg_rd && reg_addr == dsfr_pkg::ADDR_PWR;
  endsequence

  AST_HOLD1_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && second_loop_holdover |=> q.flags[dsfr_pkg::FLAG_HOLD1])
    else $error("Second loop holdover flag did not set.");
  AST_LOCK1_SETS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && second_loop_locked |=> q.flags[dsfr_pkg::FLAG_LOCK1])
    else $error("Second loop lock flag did not set.");
  AST_FLAGS_NO_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    s_flags_write_only ##0 s_no_status |=> q.flags == $past(q.flags))
    else $error("Flag register changed by a write.");
  AST_PML0_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    s_pml0_write |=> input0_phase_memory_code == $past(reg_wdata))
    else $error("Reference 0 limit not written.");
  AST_PML1_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    s_pml1_write |=> input1_phase_memory_code == $past(reg_wdata))
    else $error("Reference 1 limit not written.");
  AST_PWR_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
    s_pwr_read |=> reg_rdata == $past(diff_output_low_power))
    else $error("Output power register read back wrongly.");
  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !reg_rd |=> reg_rdata == dsfr_pkg::RDATA_NONE)
    else $error("Read data did not return to idle after its cycle.");
endmodule

/* File: test/test_dsfr_regs.sv */
// Self-checking bench for the loop status and feedback register slice.
`timescale 1ns/100ps
module test_dsfr_regs;
  logic                 clock = 1'b0;
  logic                 nrst  = 1'b0;
  logic                 ce    = 1'b1;
  logic [7:0]           reg_addr  = 8'h00;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [7:0]           reg_wdata = 8'h00;
  logic [7:0]           reg_rdata;
  logic [3:0]           st = 4'h0;
  logic [7:0]           fm = 8'h00;
  logic [7:0]           sm = 8'h00;
  // Fixed phases keep every reference frequency locked to the others.
  logic [3:0][15:0]     ph = {16'hcdef, 16'h89ab, 16'h4567, 16'h0123};
  logic [1:0][1:0]      act = {2'd1, 2'd2};
  logic [7:0]           pwr, c0, c1;
  logic                 f_on, f_loop;
  logic [1:0]           f_src;
  logic [15:0]          fbp, e;
  logic [1:0][15:0]     cph;
  int                   n_fail = 0;
  int                   samples_checked = 0;
  always #4 clock = ~clock;
  dsfr_regs u_dut (
    .clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .first_loop_holdover(st[0]), .first_loop_locked(st[1]),
    .second_loop_holdover(st[2]), .second_loop_locked(st[3]),
    .first_loop_mode(fm), .second_loop_mode(sm), .ref_phase(ph), .loop_active_ref(act),
    .diff_output_low_power(pwr), .input0_phase_memory_code(c0),
    .input1_phase_memory_code(c1), .feedback_measure_on(f_on),
    .feedback_loop_choice(f_loop), .feedback_source_choice(f_src),
    .feedback_phase(fbp), .loop_comp_phase(cph)
  );
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One-cycle write strobe; the new value is on the outputs after the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the taking edge, so it is sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, ex}, {8'h00, reg_rdata});
  endtask
  // A stuck run counts as a mismatch and still reaches the verdict.
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(dsfr_pkg::ADDR_FLAGS, dsfr_pkg::RST_FLAGS);
    rd(dsfr_pkg::ADDR_FB, dsfr_pkg::RST_FB);
    rd(dsfr_pkg::ADDR_PWR, dsfr_pkg::RST_PWR);
    rd(dsfr_pkg::ADDR_PML0, dsfr_pkg::RST_PML);
    rd(dsfr_pkg::ADDR_PML1, dsfr_pkg::RST_PML);
    rd(8'h49, dsfr_pkg::RDATA_NONE);
    chk("diff_output_low_power", 16'h00ff, {8'h00, pwr});
    wr(dsfr_pkg::ADDR_PWR, 8'h5a);
    chk("diff_output_low_power", 16'h005a, {8'h00, pwr});
    wr(dsfr_pkg::ADDR_PML0, dsfr_pkg::PML_100US);
    wr(dsfr_pkg::ADDR_PML1, dsfr_pkg::PML_1MS);
    wr(8'h49, 8'h33);
    chk("input0_phase_memory_code", 16'h0020, {8'h00, c0});
    chk("input1_phase_memory_code", 16'h0040, {8'h00, c1});
    rd(dsfr_pkg::ADDR_PML0, dsfr_pkg::PML_100US);
    wr(dsfr_pkg::ADDR_PML0, dsfr_pkg::PML_10US);
    rd(dsfr_pkg::ADDR_PML1, dsfr_pkg::PML_1MS);
    wr(dsfr_pkg::ADDR_FB, 8'hff);
    rd(dsfr_pkg::ADDR_FB, 8'h8d);
    wr(dsfr_pkg::ADDR_FLAGS, 8'hff);
    rd(dsfr_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clock);
    ce <= 1'b0;
    wr(dsfr_pkg::ADDR_PWR, 8'h00);
    @(posedge clock);
    ce <= 1'b1;
    rd(dsfr_pkg::ADDR_PWR, 8'h5a);
    // Each status level is pulsed once and must survive until the clearing read.
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      st <= 4'h1 << i;
      @(posedge clock);
      st <= 4'h0;
      rd(dsfr_pkg::ADDR_FLAGS, 8'h01 << i);
      rd(dsfr_pkg::ADDR_FLAGS, 8'h00);
    end
    // All four conditions held across clearing reads: each read sets them again.
    @(posedge clock);
    st <= 4'hf;
    rd(dsfr_pkg::ADDR_FLAGS, 8'h0f);
    rd(dsfr_pkg::ADDR_FLAGS, 8'h0f);
    @(posedge clock);
    st <= 4'h0;
    rd(dsfr_pkg::ADDR_FLAGS, 8'h0f);
    rd(dsfr_pkg::ADDR_FLAGS, 8'h00);
    // Every loop choice and source code, with compensation on either loop.
    for (int m = 0; m < 2; m++) begin
      @(posedge clock);
      fm <= (m == 1) ? 8'h20 : 8'h00;
      sm <= (m == 1) ? 8'h00 : 8'h20;
      for (int l = 0; l < 2; l++) begin
        for (int s = 0; s < 4; s++) begin
          wr(dsfr_pkg::ADDR_FB, {1'b1, 3'b000, 2'(s), 1'b0, 1'(l)});
          chk("feedback_source_choice", 16'(s), {14'h0000, f_src});
          chk("feedback_loop_choice", 16'(l), {15'h0000, f_loop});
          chk("feedback_measure_on", 16'h0001, {15'h0000, f_on});
          @(posedge clock);
          #1;
          e = ph[act[l]] - ph[s];
          chk("feedback_phase", e, fbp);
          chk("loop_comp_phase0", (m == 1) ? e : 16'h0000, cph[0]);
          chk("loop_comp_phase1", (m == 1) ? 16'h0000 : e, cph[1]);
        end
      end
    end
    wr(dsfr_pkg::ADDR_FB, 8'h0d);
    chk("feedback_measure_on", 16'h0000, {15'h0000, f_on});
    @(posedge clock);
    #1;
    chk("feedback_phase", 16'h0000, fbp);
    report_and_stop();
  end
endmodule
